// File: rtl/mrs_consts.vh
/*
  Constants for the reset and start-up sequencer of the small 8-bit core:
  reset values, post-reset clock counts and time-slot codes.
  Assumes inclusion by bare name from the sequencer module.
*/
`ifndef MRS_CONSTS_VH
`define MRS_CONSTS_VH

// ----------------------------------------------------------------------
// Post-reset timing, in oscillator clock pulses
// ----------------------------------------------------------------------
`define MRS_BUS_RELEASE_CLKS 30
`define MRS_REL_MARGIN 8
`define MRS_EXEC_START_CLKS 1866
`define MRS_CNT_W 11

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MRS_PC_RST 13'h0000
`define MRS_SP_RST 3'h0
`define MRS_SP_BASE 8'h08
`define MRS_MEM_BANK_RST 1'h0
`define MRS_REG_BANK_RST 1'h0
`define MRS_PRESCALE_RST 6'h20
`define MRS_TIMER_RST 8'h00
// Bit 19 is port two bit three, which stays with the serial data line
`define MRS_PORT_MODE_RST 20'h7ffff

// ----------------------------------------------------------------------
// Machine cycle: ten time slots, one per oscillator pulse here
// ----------------------------------------------------------------------
`define MRS_SLOTS 10
`define MRS_SLOT_W 4
`define MRS_SIXTH_SLOT 4'h5

// ----------------------------------------------------------------------
// Data memory
// ----------------------------------------------------------------------
`define MRS_RAM_DEPTH 256
`define MRS_DIRECT_LOCS 16
`define MRS_STACK_LEVELS 8
`define MRS_PORT_BITS 20

`endif

// File: rtl/mrs_reset_sequencer.v
/*
  Reset and start-up sequencer for a small 8-bit core. Holds the reset
  image of the core state, the data RAM with its return stack, the
  post-reset release counts and the derivative interrupt gate.
  Assumes ref_clk_in is the oscillator; all pin inputs are asynchronous
  and are synchronised here. Core-side inputs share the clock.
*/
//
// Behaviour
// - Reset pin is an active-high input, also driven by power-on-reset.
// - Reset clears program counter; execution starts from address zero.
// - Reset selects memory bank 0 location 0 and register bank 0.
// - Reset loads stack pointer 000, addressing data RAM location 8.
// - Reset clears external, timer and serial-bus interrupt enables.
// - Reset halts the timer/event counter, then clears its count.
// - Reset sets the timer prescaler to divide by 32.
// - Reset clears the timer overflow flag.
// - Reset makes every port bit input except port two bit three.
// - Reset puts serial bus in slave-receiver mode, disabled.
// - Reset leaves idle and stop low-power states.
// - Within 30 clocks after release, drive serial data and clock high.
// - Within 30 clocks after release, serial bus slave-receiver, disabled.
// - Wait 1866 clocks after release before fetching the first instruction.
// - 256-byte data RAM, all indirect, up to 16 direct locations.
// - Eight-level return stack in data RAM, 3-bit stack pointer.
// - Active-low derivative interrupt, pulled high, ORed with serial interrupt.
// - Sample only in sixth time slot; need enable and no running routine.
// - Derivative requests are not latched; early release is lost.
`timescale 1ns/100ps
`include "mrs_consts.vh"

module mrs_reset_sequencer (
  input wire ref_clk_in,
  input wire sys_rst_in,
  input wire reset_pin_in,
  input wire por_req_in,
  output wire reset_pin_out,
  output wire reset_pin_oe_out,
  input wire ext_derivative_irq_n_in,
  input wire serial_irq_req_in,
  input wire serial_irq_en_set_in,
  input wire in_irq_routine_in,
  input wire idle_req_in,
  input wire stop_req_in,
  input wire ram_we_in,
  input wire [7:0] ram_addr_in,
  input wire [7:0] ram_wdata_in,
  input wire [3:0] ram_direct_sel_in,
  input wire ram_direct_in,
  input wire stack_push_in,
  input wire stack_pop_in,
  input wire [12:0] stack_push_pc_in,
  output reg [7:0] ram_rdata_out,
  output reg [12:0] stack_pop_pc_out,
  output reg [2:0] stack_ptr_out,
  output reg core_reset_out,
  output reg fetch_enable_out,
  output reg [12:0] pc_out,
  output reg mem_bank_out,
  output reg reg_bank_out,
  output reg ext_irq_en_out,
  output reg timer_irq_en_out,
  output reg serial_irq_en_out,
  output reg timer_run_out,
  output reg [7:0] timer_count_out,
  output reg [5:0] prescale_div_out,
  output reg timer_flag_out,
  output reg [`MRS_PORT_BITS-1:0] port_input_mode_out,
  output reg serial_slave_rx_out,
  output reg serial_enable_out,
  output reg idle_out,
  output reg stop_out,
  output reg sda_out,
  output reg sda_oe_out,
  output reg scl_out,
  output reg scl_oe_out,
  output reg [`MRS_SLOT_W-1:0] time_slot_out,
  output reg derivative_irq_take_out
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  reg rst_s1;
  reg rst_s2;
  reg irq_s1;
  reg irq_s2;

  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rst_s1 <= 1'b1;
      rst_s2 <= 1'b1;
      irq_s1 <= 1'b1;
      irq_s2 <= 1'b1;
    end else begin
      rst_s1 <= reset_pin_in;
      rst_s2 <= rst_s1;
      irq_s1 <= ext_derivative_irq_n_in;
      irq_s2 <= irq_s1;
    end
  end

  // Power-on-reset drives the shared pin high; the pin value read back
  // covers both external and internal sources.
  assign reset_pin_out = 1'b1;
  assign reset_pin_oe_out = por_req_in;

  wire rst_active;
  assign rst_active = rst_s2 | por_req_in;

  // ----------------------------------------------------------------------
  // Release sequencer
  // ----------------------------------------------------------------------
  localparam ST_HOLD = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_RUN = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`MRS_CNT_W-1:0] rel_cnt;
  reg [`MRS_CNT_W-1:0] next_rel_cnt;

  always @* begin
    next_state = state;
    next_rel_cnt = rel_cnt;
    case (state)
      ST_HOLD: begin
        next_rel_cnt = {`MRS_CNT_W{1'b0}};
        if (!rst_active) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (rst_active) begin
          next_state = ST_HOLD;
        end else if (rel_cnt == `MRS_EXEC_START_CLKS - 1) begin
          next_state = ST_RUN;
        end else begin
          next_rel_cnt = rel_cnt + 1'b1;
        end
      end
      ST_RUN: begin
        if (rst_active) begin
          next_state = ST_HOLD;
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
  end

  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_HOLD;
      rel_cnt <= {`MRS_CNT_W{1'b0}};
    end else begin
      state <= next_state;
      rel_cnt <= next_rel_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // Reset image of core state
  // ----------------------------------------------------------------------
  // Fetch rises on the edge that enters the run state, so the slot counter
  // starts from zero with the first instruction.
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      core_reset_out <= 1'b1;
      fetch_enable_out <= 1'b0;
      pc_out <= `MRS_PC_RST;
      mem_bank_out <= `MRS_MEM_BANK_RST;
      reg_bank_out <= `MRS_REG_BANK_RST;
    end else if (rst_active) begin
      core_reset_out <= 1'b1;
      fetch_enable_out <= 1'b0;
      pc_out <= `MRS_PC_RST;
      mem_bank_out <= `MRS_MEM_BANK_RST;
      reg_bank_out <= `MRS_REG_BANK_RST;
    end else if (next_state == ST_RUN) begin
      core_reset_out <= 1'b0;
      fetch_enable_out <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt enables
  // ----------------------------------------------------------------------
  // Only the serial enable has a set path here; the other two belong to
  // the core and are only ever cleared by this block.
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ext_irq_en_out <= 1'b0;
      timer_irq_en_out <= 1'b0;
      serial_irq_en_out <= 1'b0;
    end else if (rst_active) begin
      ext_irq_en_out <= 1'b0;
      timer_irq_en_out <= 1'b0;
      serial_irq_en_out <= 1'b0;
    end else if (serial_irq_en_set_in && state == ST_RUN) begin
      serial_irq_en_out <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Timer reset
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      timer_run_out <= 1'b0;
      timer_count_out <= `MRS_TIMER_RST;
      prescale_div_out <= `MRS_PRESCALE_RST;
      timer_flag_out <= 1'b0;
    end else if (rst_active) begin
      // Run is dropped first; the count is cleared on the next edge
      timer_run_out <= 1'b0;
      if (!timer_run_out) begin
        timer_count_out <= `MRS_TIMER_RST;
      end
      prescale_div_out <= `MRS_PRESCALE_RST;
      timer_flag_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Port modes
  // ----------------------------------------------------------------------
  // Port two bit three doubles as the serial data line; reset leaves its
  // mode to the serial interface instead of forcing it to input.
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      port_input_mode_out <= `MRS_PORT_MODE_RST;
    end else if (rst_active) begin
      port_input_mode_out <= `MRS_PORT_MODE_RST;
    end
  end

  // ----------------------------------------------------------------------
  // Serial interface release
  // ----------------------------------------------------------------------
  // The pin synchroniser and the entry into the wait state spend three edges
  // of the 30-pulse budget; releasing at this count leaves spare pulses.
  wire bus_release;
  assign bus_release = (state == ST_WAIT) &&
    (rel_cnt == `MRS_BUS_RELEASE_CLKS - `MRS_REL_MARGIN);

  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      serial_slave_rx_out <= 1'b1;
      serial_enable_out <= 1'b0;
      sda_out <= 1'b1;
      sda_oe_out <= 1'b0;
      scl_out <= 1'b1;
      scl_oe_out <= 1'b0;
    end else if (rst_active) begin
      serial_slave_rx_out <= 1'b1;
      serial_enable_out <= 1'b0;
      sda_oe_out <= 1'b0;
      scl_oe_out <= 1'b0;
    end else if (bus_release) begin
      sda_out <= 1'b1;
      sda_oe_out <= 1'b1;
      scl_out <= 1'b1;
      scl_oe_out <= 1'b1;
      serial_slave_rx_out <= 1'b1;
      serial_enable_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Low-power states
  // ----------------------------------------------------------------------
  // Reset outranks a request in the same cycle: a core being reset must
  // come back awake.
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      idle_out <= 1'b0;
      stop_out <= 1'b0;
    end else if (rst_active) begin
      idle_out <= 1'b0;
      stop_out <= 1'b0;
    end else if (state == ST_RUN) begin
      if (idle_req_in) begin
        idle_out <= 1'b1;
      end
      if (stop_req_in) begin
        stop_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Time slots and derivative interrupt gate
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      time_slot_out <= {`MRS_SLOT_W{1'b0}};
    end else if (state != ST_RUN) begin
      time_slot_out <= {`MRS_SLOT_W{1'b0}};
    end else if (time_slot_out == `MRS_SLOTS - 1) begin
      time_slot_out <= {`MRS_SLOT_W{1'b0}};
    end else begin
      time_slot_out <= time_slot_out + 1'b1;
    end
  end

  // Pull-up is assumed at the pad; a floating input reads inactive.
  wire irq_combined;
  assign irq_combined = ~irq_s2 | serial_irq_req_in;

  // Level sampled, never stored: a request gone before the slot is lost,
  // so the source must hold it until the vector fetch.
  reg next_irq_take;

  always @* begin
    next_irq_take = 1'b0;
    if ((state == ST_RUN) && (time_slot_out == `MRS_SIXTH_SLOT)) begin
      next_irq_take = irq_combined && serial_irq_en_out && !in_irq_routine_in;
    end
  end

  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      derivative_irq_take_out <= 1'b0;
    end else begin
      derivative_irq_take_out <= next_irq_take;
    end
  end

  // ----------------------------------------------------------------------
  // Data RAM and return stack
  // ----------------------------------------------------------------------
  // Stack frames are two bytes from location 8; direct locations are
  // the lowest sixteen addresses.
  reg [7:0] ram [0:`MRS_RAM_DEPTH-1];
  wire [7:0] eff_addr;
  wire [7:0] push_addr;
  wire [2:0] pop_ptr;
  wire [7:0] pop_addr;

  assign eff_addr = ram_direct_in ? {4'h0, ram_direct_sel_in} : ram_addr_in;
  assign push_addr = `MRS_SP_BASE + {4'h0, stack_ptr_out, 1'b0};
  assign pop_ptr = stack_ptr_out - 3'h1;
  assign pop_addr = `MRS_SP_BASE + {4'h0, pop_ptr, 1'b0};

  always @(posedge ref_clk_in) begin
    if (!rst_active && stack_push_in) begin
      ram[push_addr] <= stack_push_pc_in[7:0];
      ram[push_addr + 8'h01] <= {3'h0, stack_push_pc_in[12:8]};
    end else if (!rst_active && ram_we_in) begin
      ram[eff_addr] <= ram_wdata_in;
    end
  end

  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stack_ptr_out <= `MRS_SP_RST;
      ram_rdata_out <= 8'h00;
      stack_pop_pc_out <= 13'h0000;
    end else if (rst_active) begin
      stack_ptr_out <= `MRS_SP_RST;
      ram_rdata_out <= 8'h00;
      stack_pop_pc_out <= 13'h0000;
    end else begin
      ram_rdata_out <= ram[eff_addr];
      if (stack_push_in) begin
        stack_ptr_out <= stack_ptr_out + 3'h1;
      end else if (stack_pop_in) begin
        stack_ptr_out <= pop_ptr;
        stack_pop_pc_out <= {ram[pop_addr + 8'h01][4:0], ram[pop_addr]};
      end
    end
  end

endmodule // mrs_reset_sequencer

// File: sim/mrs_seq_assertions.sv
/* Checker on the sequencer ports.
   Assumes one clock domain; bound at the foot of this file. */
`timescale 1ns/100ps
module mrs_seq_assertions (
  input wire ref_clk_in,
  input wire sys_rst_in,
  input wire reset_pin_in,
  input wire por_req_in,
  input wire reset_pin_out,
  input wire reset_pin_oe_out,
  input wire in_irq_routine_in,
  input wire core_reset_out,
  input wire fetch_enable_out,
  input wire [12:0] pc_out,
  input wire [2:0] stack_ptr_out,
  input wire ext_irq_en_out,
  input wire serial_irq_en_out,
  input wire [5:0] prescale_div_out,
  input wire idle_out,
  input wire stop_out,
  input wire sda_oe_out,
  input wire scl_oe_out,
  input wire [3:0] time_slot_out,
  input wire derivative_irq_take_out
);
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // ------------
  // Pin-low cycles, restarted by any new reset
  // ------------
  logic [11:0] low_cnt;
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      low_cnt <= 12'h000;
    else if (reset_pin_in)
      low_cnt <= 12'h000;
    else if (low_cnt != 12'hfff)
      low_cnt <= low_cnt + 12'h001;
  end
  // Two edges of slack so the image may land after a pin reset
  sequence s_held;
    core_reset_out && $past(core_reset_out, 2);
  endsequence
  AST_PIN: assert property (reset_pin_oe_out == por_req_in && reset_pin_out)
    else $error("reset pin drive wrong");
  AST_PC_SP: assert property (s_held |-> pc_out == 13'h0000 && stack_ptr_out == 3'h0)
    else $error("pc or stack pointer not cleared");
  AST_IRQ_EN: assert property (s_held |-> !ext_irq_en_out && !serial_irq_en_out)
    else $error("interrupt enable left set");
  AST_PRESCALE: assert property (s_held |-> prescale_div_out == 6'h20)
    else $error("prescaler not 32");
  AST_LOWPWR: assert property (s_held |-> !idle_out && !stop_out)
    else $error("low power state kept");
  AST_BUS_REL: assert property (low_cnt == 12'h01e |-> sda_oe_out && scl_oe_out)
    else $error("serial lines not released");
  AST_FETCH_MIN: assert property (low_cnt == 12'h74a |-> !fetch_enable_out)
    else $error("fetch too early");
  AST_FETCH_MAX: assert property (low_cnt == 12'h750 |-> fetch_enable_out)
    else $error("fetch too late");
  AST_SLOT: assert property (fetch_enable_out && $past(fetch_enable_out, 2) |->
    time_slot_out == ($past(time_slot_out) == 4'h9 ? 4'h0 : $past(time_slot_out) + 4'h1))
    else $error("time slot sequence wrong");
  AST_TAKE: assert property (derivative_irq_take_out |->
    $past(time_slot_out) == 4'h5 && !$past(in_irq_routine_in) && $past(serial_irq_en_out))
    else $error("interrupt taken out of slot");
endmodule // mrs_seq_assertions
bind mrs_reset_sequencer mrs_seq_assertions u_chk (.*);

// File: sim/mrs_reset_src.sv
/* External reset source and interrupt-emulating hardware.
   Assumes the caller runs its tasks from the bench clock. */
`timescale 1ns/100ps
module mrs_reset_src (
  input wire ref_clk_in,
  output logic rst_drive_out,
  output logic irq_n_out
);
  initial begin
    rst_drive_out = 1'h1;
    irq_n_out = 1'h1;
  end
  task automatic pulse_reset(input int n);
    @(posedge ref_clk_in);
    rst_drive_out <= 1'h1;
    repeat (n) @(posedge ref_clk_in);
    rst_drive_out <= 1'h0;
  endtask
  // No vector bus here, so the hold is a fixed count
  task automatic request(input int n);
    @(posedge ref_clk_in);
    irq_n_out <= 1'h0;
    repeat (n) @(posedge ref_clk_in);
    irq_n_out <= 1'h1;
  endtask
endmodule // mrs_reset_src

// File: sim/mrs_reset_sequencer_tb.sv
/* Self-checking bench for the reset sequencer.
   Assumes the checker binds itself and the source model drives the pin. */
`timescale 1ns/100ps
`include "mrs_consts.vh"
module mrs_reset_sequencer_tb;
  typedef struct packed {
    logic d;
    logic [3:0] sel;
    logic [7:0] a, wd, ra, exp;
  } mrs_row_t;
  logic ref_clk_in = 1'h0;
  logic sys_rst_in, por_req_in, serial_irq_req_in, serial_irq_en_set_in, in_irq_routine_in;
  logic idle_req_in, stop_req_in, ram_we_in, ram_direct_in, stack_push_in, stack_pop_in;
  logic [7:0] ram_addr_in, ram_wdata_in, ram_rdata_out, timer_count_out;
  logic [3:0] ram_direct_sel_in, time_slot_out;
  logic [12:0] stack_push_pc_in, stack_pop_pc_out, pc_out;
  logic [2:0] stack_ptr_out;
  logic [5:0] prescale_div_out;
  logic [`MRS_PORT_BITS-1:0] port_input_mode_out;
  logic reset_pin_out, reset_pin_oe_out, core_reset_out, fetch_enable_out, mem_bank_out;
  logic reg_bank_out, ext_irq_en_out, timer_irq_en_out, serial_irq_en_out, timer_run_out;
  logic timer_flag_out, serial_slave_rx_out, serial_enable_out, idle_out, stop_out;
  logic sda_out, sda_oe_out, scl_out, scl_oe_out, derivative_irq_take_out, rst_drv;
  wire ext_derivative_irq_n_in;
  wire reset_pin_in = rst_drv | (reset_pin_oe_out & reset_pin_out);
  int checks = 0, n_mismatch = 0, n_take = 0, cyc = 0, n;
  mrs_row_t rows [3] = '{'{1'h0, 4'h0, 8'hff, 8'h5a, 8'hff, 8'h5a},
    '{1'h1, 4'hf, 8'h00, 8'h3c, 8'h0f, 8'h3c}, '{1'h1, 4'h0, 8'h00, 8'hc3, 8'h00, 8'hc3}};
  mrs_reset_sequencer u_dut (.*);
  mrs_reset_src u_src (.ref_clk_in(ref_clk_in), .rst_drive_out(rst_drv),
    .irq_n_out(ext_derivative_irq_n_in));
  always #50 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (derivative_irq_take_out === 1'h1)
      n_take <= n_take + 1;
    if (cyc == 12000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict();
    end
  end
  // ------------
  // Shared tasks
  // ------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic img;
    chk({core_reset_out, fetch_enable_out}, 2'h2);
    chk({pc_out, mem_bank_out, reg_bank_out, stack_ptr_out}, 18'h0);
    chk({ext_irq_en_out, timer_irq_en_out, serial_irq_en_out}, 3'h0);
    chk({timer_run_out, timer_count_out, timer_flag_out}, 10'h0);
    chk(prescale_div_out, 6'h20);
    chk(port_input_mode_out, 20'h7ffff);
    chk({serial_slave_rx_out, serial_enable_out, idle_out, stop_out}, 4'h8);
  endtask
  task automatic run_up(input int hold);
    u_src.pulse_reset(hold);
    n = 0;
    while (fetch_enable_out !== 1'h1 && n < 3000) begin
      @(negedge ref_clk_in);
      n = n + 1;
      if (n == 30)
        chk({sda_oe_out, scl_oe_out, sda_out, scl_out, serial_enable_out}, 5'h1e);
    end
    chk(n >= 1866 && n <= 1872, 1'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    ram_we_in <= 1'h0;
    ram_direct_in <= 1'h0;
    ram_addr_in <= a;
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk(ram_rdata_out, e);
  endtask
  task automatic pulse_in(input int k);
    @(posedge ref_clk_in);
    {idle_req_in, stop_req_in, serial_irq_en_set_in, stack_push_in, stack_pop_in} <= 5'h1 << k;
    @(posedge ref_clk_in);
    {idle_req_in, stop_req_in, serial_irq_en_set_in, stack_push_in, stack_pop_in} <= 5'h0;
    @(negedge ref_clk_in);
  endtask
  // ------------
  // Main sequence
  // ------------
  initial begin
    sys_rst_in = 1'h1;
    {por_req_in, serial_irq_req_in, serial_irq_en_set_in, in_irq_routine_in} = 4'h0;
    {idle_req_in, stop_req_in, ram_we_in, ram_direct_in, stack_push_in, stack_pop_in} = 6'h0;
    {ram_addr_in, ram_wdata_in, ram_direct_sel_in, stack_push_pc_in} = 33'h0;
    repeat (16) @(posedge ref_clk_in);
    sys_rst_in <= 1'h0;
    repeat (3) @(negedge ref_clk_in);
    img();
    run_up(4);
    foreach (rows[i]) begin
      @(posedge ref_clk_in);
      {ram_we_in, ram_direct_in, ram_direct_sel_in} <= {1'h1, rows[i].d, rows[i].sel};
      {ram_addr_in, ram_wdata_in} <= {rows[i].a, rows[i].wd};
      rd(rows[i].ra, rows[i].exp);
    end
    @(posedge ref_clk_in);
    stack_push_pc_in <= 13'h1abc;
    pulse_in(1);
    chk(stack_ptr_out, 3'h1);
    rd(8'h08, 8'hbc);
    rd(8'h09, 8'h1a);
    pulse_in(0);
    chk({stack_pop_pc_out, stack_ptr_out}, 16'hd5e0);
    pulse_in(2);
    u_src.request(10);
    repeat (6) @(posedge ref_clk_in);
    chk(n_take, 1);
    in_irq_routine_in <= 1'h1;
    u_src.request(10);
    repeat (6) @(posedge ref_clk_in);
    chk(n_take, 1);
    in_irq_routine_in <= 1'h0;
    serial_irq_req_in <= 1'h1;
    repeat (10) @(posedge ref_clk_in);
    serial_irq_req_in <= 1'h0;
    repeat (4) @(posedge ref_clk_in);
    chk(n_take, 2);
    pulse_in(4);
    chk(idle_out, 1'h1);
    @(posedge ref_clk_in);
    por_req_in <= 1'h1;
    @(negedge ref_clk_in);
    chk(reset_pin_oe_out, 1'h1);
    repeat (5) @(negedge ref_clk_in);
    img();
    @(posedge ref_clk_in);
    por_req_in <= 1'h0;
    repeat (500) @(posedge ref_clk_in);
    run_up(3);
    print_verdict();
  end
endmodule // mrs_reset_sequencer_tb
